// ==== rtl/sfl_dev.sv ====
`include "sfl_defs.svh"

module sfl_dev (
  sfl_if.dev lnk,
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] rd_data,
  output logic [`SFL_ADDR_W-1:0] rd_addr,
  output sfl_pkg::sfl_kind_type rd_kind,
  output logic cmd_valid,
  output sfl_pkg::sfl_kind_type cmd_kind,
  output logic [7:0] cmd_opcode,
  output logic [`SFL_ADDR_W-1:0] cmd_addr,
  output logic [8:0] cmd_len,
  output logic [7:0] wdata,
  output logic wdata_valid
);
  import sfl_pkg::*;

  // ===================================================================
  // Link domain state
  typedef enum logic [5:0] {
    ST_OPC = 6'h01,
    ST_ADDR = 6'h02,
    ST_DUMMY = 6'h04,
    ST_WR = 6'h08,
    ST_RD = 6'h10,
    ST_IGN = 6'h20
  } sfl_dev_state_type;

  logic link_rst_n;
  sfl_dev_state_type st_ff, nxt_st;
  logic [2:0] bit_ff, nxt_bit;
  logic [1:0] byte_ff, nxt_byte;
  logic [2:0] out_cnt_ff, nxt_out_cnt;
  logic [6:0] sh_ff, nxt_sh;
  logic [`SFL_ADDR_W-1:0] addr_ff, nxt_addr;
  sfl_attr_type attr_ff, nxt_attr;
  logic [7:0] byte_in;
  logic last;
  logic tgl_ff, nxt_tgl;
  logic [7:0] ev_byte_ff, nxt_ev_byte;
  sfl_phase_type ev_phase_ff, nxt_ev_phase;
  logic ev_done_ff, nxt_ev_done;
  logic so_ff, nxt_so;
  logic so_oe_ff, nxt_so_oe;

  function automatic sfl_dev_state_type after_hdr(input sfl_attr_type a);
    if (a.dir_out) begin
      return ST_RD;
    end else if (a.dir_in) begin
      return ST_WR;
    end else begin
      return ST_IGN;
    end
  endfunction : after_hdr

  assign link_rst_n = nrst & ~lnk.cs_n;
  assign byte_in = {sh_ff, lnk.mosi};
  assign last = (bit_ff == 3'h7);

  // ===================================================================
  // Link next state
  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff + 3'h1;
    nxt_sh = byte_in[6:0];
    nxt_byte = byte_ff;
    nxt_out_cnt = out_cnt_ff;
    nxt_addr = addr_ff;
    nxt_attr = attr_ff;
    nxt_tgl = tgl_ff;
    nxt_ev_byte = ev_byte_ff;
    nxt_ev_phase = ev_phase_ff;
    nxt_ev_done = ev_done_ff;
    case (st_ff)
      ST_OPC: begin
        if (last) begin
          nxt_attr = sfl_decode(byte_in);
          nxt_byte = 2'h0;
          nxt_tgl = ~tgl_ff;
          nxt_ev_byte = byte_in;
          nxt_ev_phase = PH_OPC;
          nxt_ev_done = 1'b0;
          if (nxt_attr.kind == K_NONE) begin
            nxt_st = ST_IGN;
          end else if (nxt_attr.n_addr != 2'h0) begin
            nxt_st = ST_ADDR;
          end else begin
            nxt_st = after_hdr(nxt_attr);
            nxt_ev_done = 1'b1;
          end
        end
      end
      ST_ADDR: begin
        if (last) begin
          nxt_addr = {addr_ff[`SFL_ADDR_W-9:0], byte_in};
          nxt_tgl = ~tgl_ff;
          nxt_ev_byte = byte_in;
          nxt_ev_phase = PH_ADDR;
          nxt_ev_done = 1'b0;
          if (byte_ff == attr_ff.n_addr - 2'h1) begin
            nxt_byte = 2'h0;
            if (attr_ff.n_dummy != 2'h0) begin
              nxt_st = ST_DUMMY;
            end else begin
              nxt_st = after_hdr(attr_ff);
              nxt_ev_done = 1'b1;
            end
          end else begin
            nxt_byte = byte_ff + 2'h1;
          end
        end
      end
      ST_DUMMY: begin
        if (last) begin
          nxt_tgl = ~tgl_ff;
          nxt_ev_byte = byte_in;
          nxt_ev_phase = PH_DUMMY;
          nxt_ev_done = 1'b0;
          if (byte_ff == attr_ff.n_dummy - 2'h1) begin
            nxt_st = after_hdr(attr_ff);
            nxt_ev_done = 1'b1;
          end else begin
            nxt_byte = byte_ff + 2'h1;
          end
        end
      end
      ST_WR: begin
        if (last) begin
          nxt_tgl = ~tgl_ff;
          nxt_ev_byte = byte_in;
          nxt_ev_phase = PH_DATA;
          if (attr_ff.kind == K_WRITE_STATUS) begin
            nxt_st = ST_IGN;
          end
        end
      end
      ST_RD: begin
        if (last) begin
          if (attr_ff.kind == K_READ_ID) begin
            nxt_out_cnt = out_cnt_ff + 3'h1;
            if (out_cnt_ff == `SFL_ID_BYTES - 3'h1) begin
              nxt_st = ST_IGN;
            end
          end else if (attr_ff.kind != K_READ_STATUS) begin
            nxt_addr = addr_ff + `SFL_ADDR_W'(1);
          end
        end
      end
      ST_IGN: begin
        nxt_st = ST_IGN;
      end
      default: begin
        nxt_st = ST_OPC;
      end
    endcase
  end

  always_ff @(posedge lnk.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_ff <= ST_OPC;
      bit_ff <= 3'h0;
      byte_ff <= 2'h0;
      out_cnt_ff <= 3'h0;
      sh_ff <= 7'h00;
      addr_ff <= '0;
      attr_ff <= '{K_NONE, 2'h0, 2'h0, 1'b0, 1'b0};
    end else begin
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      byte_ff <= nxt_byte;
      out_cnt_ff <= nxt_out_cnt;
      sh_ff <= nxt_sh;
      addr_ff <= nxt_addr;
      attr_ff <= nxt_attr;
    end
  end

  // Byte events survive deselect so the system side still sees them
  always_ff @(posedge lnk.sck or negedge nrst) begin
    if (!nrst) begin
      tgl_ff <= 1'b0;
      ev_byte_ff <= 8'h00;
      ev_phase_ff <= PH_OPC;
      ev_done_ff <= 1'b0;
    end else begin
      tgl_ff <= nxt_tgl;
      ev_byte_ff <= nxt_ev_byte;
      ev_phase_ff <= nxt_ev_phase;
      ev_done_ff <= nxt_ev_done;
    end
  end

  // ===================================================================
  // Serial output on falling edge
  always_comb begin
    nxt_so = rd_data[~bit_ff];
    nxt_so_oe = (st_ff == ST_RD);
  end

  always_ff @(negedge lnk.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_ff <= nxt_so;
      so_oe_ff <= nxt_so_oe;
    end
  end

  assign lnk.so = so_ff;
  assign lnk.so_oe = so_oe_ff;
  assign rd_addr = addr_ff;
  assign rd_kind = attr_ff.kind;

  // ===================================================================
  // System side command capture
  logic tgl_s, cs_s;
  logic tgl_d_ff, cs_d_ff, cs_e_ff;
  logic ev, frame_end;
  sfl_attr_type ev_attr;
  logic hdr_ok_ff, nxt_hdr_ok;
  logic cmd_valid_ff, nxt_cmd_valid;
  sfl_kind_type kind_ff, nxt_kind;
  logic [7:0] opc_ff, nxt_opc;
  logic [`SFL_ADDR_W-1:0] caddr_ff, nxt_caddr;
  logic [8:0] len_ff, nxt_len;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wvalid_ff, nxt_wvalid;

  sfl_sync #(.RST_VAL(1'b0)) u_sync_tgl (
    .clk(clk_sys),
    .nrst(nrst),
    .d(tgl_ff),
    .q(tgl_s)
  );

  sfl_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk(clk_sys),
    .nrst(nrst),
    .d(lnk.cs_n),
    .q(cs_s)
  );

  assign ev = tgl_s ^ tgl_d_ff;
  assign frame_end = cs_d_ff & ~cs_e_ff;
  assign ev_attr = sfl_decode(ev_byte_ff);

  always_comb begin
    nxt_hdr_ok = hdr_ok_ff;
    nxt_cmd_valid = 1'b0;
    nxt_kind = kind_ff;
    nxt_opc = opc_ff;
    nxt_caddr = caddr_ff;
    nxt_len = len_ff;
    nxt_wdata = wdata_ff;
    nxt_wvalid = 1'b0;
    if (ev) begin
      case (ev_phase_ff)
        PH_OPC: begin
          nxt_opc = ev_byte_ff;
          nxt_kind = ev_attr.kind;
          nxt_hdr_ok = ev_done_ff;
          nxt_len = 9'h000;
        end
        PH_ADDR: begin
          nxt_caddr = {caddr_ff[`SFL_ADDR_W-9:0], ev_byte_ff};
          nxt_hdr_ok = ev_done_ff;
        end
        PH_DUMMY: begin
          nxt_hdr_ok = ev_done_ff;
        end
        default: begin
          nxt_wdata = ev_byte_ff;
          nxt_wvalid = 1'b1;
          if (len_ff < `SFL_PAGE_BYTES) begin
            nxt_len = len_ff + 9'h001;
          end
        end
      endcase
    end
    if (frame_end) begin
      nxt_cmd_valid = hdr_ok_ff;
      nxt_hdr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tgl_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      cs_e_ff <= 1'b1;
      hdr_ok_ff <= 1'b0;
      cmd_valid_ff <= 1'b0;
      kind_ff <= K_NONE;
      opc_ff <= 8'h00;
      caddr_ff <= '0;
      len_ff <= 9'h000;
      wdata_ff <= 8'h00;
      wvalid_ff <= 1'b0;
    end else begin
      tgl_d_ff <= tgl_s;
      cs_d_ff <= cs_s;
      cs_e_ff <= cs_d_ff;
      hdr_ok_ff <= nxt_hdr_ok;
      cmd_valid_ff <= nxt_cmd_valid;
      kind_ff <= nxt_kind;
      opc_ff <= nxt_opc;
      caddr_ff <= nxt_caddr;
      len_ff <= nxt_len;
      wdata_ff <= nxt_wdata;
      wvalid_ff <= nxt_wvalid;
    end
  end

  assign cmd_valid = cmd_valid_ff;
  assign cmd_kind = kind_ff;
  assign cmd_opcode = opc_ff;
  assign cmd_addr = caddr_ff;
  assign cmd_len = len_ff;
  assign wdata = wdata_ff;
  assign wdata_valid = wvalid_ff;

endmodule : sfl_dev

// ==== rtl/sfl_defs.svh ====
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH

// =====================================================================
// Opcodes
`define SFL_OP_READ_FAST 8'h0b
`define SFL_OP_READ_SLOW 8'h03
`define SFL_OP_ERASE_4K 8'h20
`define SFL_OP_ERASE_32K 8'h52
`define SFL_OP_ERASE_64K 8'hd8
`define SFL_OP_CHIP_ERASE_A 8'h60
`define SFL_OP_CHIP_ERASE_B 8'hc7
`define SFL_OP_PROGRAM 8'h02
`define SFL_OP_WREN 8'h06
`define SFL_OP_WRDI 8'h04
`define SFL_OP_PROTECT 8'h36
`define SFL_OP_UNPROTECT 8'h39
`define SFL_OP_READ_PROT 8'h3c
`define SFL_OP_PROG_SEC 8'h9b
`define SFL_OP_READ_SEC 8'h77
`define SFL_OP_READ_STATUS 8'h05
`define SFL_OP_WRITE_STATUS 8'h01
`define SFL_OP_READ_ID 8'h9f
`define SFL_OP_SLEEP 8'hb9
`define SFL_OP_WAKE 8'hab

// =====================================================================
// Framing
`define SFL_ADDR_BYTES 2'h3
`define SFL_ADDR_W 18
`define SFL_FAST_DUMMY 2'h1
`define SFL_SEC_DUMMY 2'h2
`define SFL_PAGE_BYTES 9'h100
`define SFL_ID_BYTES 3'h4

// =====================================================================
// Timing
`define SFL_SYS_CLK_MHZ 40
`define SFL_FAST_CLOCK_LIMIT_MHZ 66
`define SFL_SLOW_READ_CLOCK_LIMIT_MHZ 33
`define SFL_SCK_HALF_MIN \
  ((`SFL_SYS_CLK_MHZ + 2 * `SFL_SLOW_READ_CLOCK_LIMIT_MHZ - 1) / (2 * `SFL_SLOW_READ_CLOCK_LIMIT_MHZ))
`define SFL_SCK_HALF_SYNC 4

`endif

// ==== rtl/sfl_pkg.sv ====
`include "sfl_defs.svh"

package sfl_pkg;

  // ===================================================================
  // Types
  typedef enum logic [4:0] {
    K_NONE, K_READ, K_ERASE, K_CHIP_ERASE, K_PROGRAM, K_PROTECT, K_UNPROTECT,
    K_READ_PROT, K_WREN, K_WRDI, K_READ_STATUS, K_WRITE_STATUS, K_PROG_SEC,
    K_READ_SEC, K_READ_ID, K_SLEEP, K_WAKE
  } sfl_kind_type;

  typedef enum logic [1:0] {
    PH_OPC = 2'h0,
    PH_ADDR = 2'h1,
    PH_DUMMY = 2'h2,
    PH_DATA = 2'h3
  } sfl_phase_type;

  typedef struct packed {
    sfl_kind_type kind;
    logic [1:0] n_addr;
    logic [1:0] n_dummy;
    logic dir_in;
    logic dir_out;
  } sfl_attr_type;

  // ===================================================================
  // Opcode decode
  function automatic sfl_attr_type sfl_decode(input logic [7:0] op);
    sfl_attr_type a;
    a = '{K_NONE, 2'h0, 2'h0, 1'b0, 1'b0};
    case (op)
      `SFL_OP_READ_FAST: a = '{K_READ, `SFL_ADDR_BYTES, `SFL_FAST_DUMMY, 1'b0, 1'b1};
      `SFL_OP_READ_SLOW: a = '{K_READ, `SFL_ADDR_BYTES, 2'h0, 1'b0, 1'b1};
      `SFL_OP_ERASE_4K, `SFL_OP_ERASE_32K, `SFL_OP_ERASE_64K:
        a = '{K_ERASE, `SFL_ADDR_BYTES, 2'h0, 1'b0, 1'b0};
      `SFL_OP_CHIP_ERASE_A, `SFL_OP_CHIP_ERASE_B: a = '{K_CHIP_ERASE, 2'h0, 2'h0, 1'b0, 1'b0};
      `SFL_OP_PROGRAM: a = '{K_PROGRAM, `SFL_ADDR_BYTES, 2'h0, 1'b1, 1'b0};
      `SFL_OP_PROTECT: a = '{K_PROTECT, `SFL_ADDR_BYTES, 2'h0, 1'b0, 1'b0};
      `SFL_OP_UNPROTECT: a = '{K_UNPROTECT, `SFL_ADDR_BYTES, 2'h0, 1'b0, 1'b0};
      `SFL_OP_READ_PROT: a = '{K_READ_PROT, `SFL_ADDR_BYTES, 2'h0, 1'b0, 1'b1};
      `SFL_OP_WREN: a = '{K_WREN, 2'h0, 2'h0, 1'b0, 1'b0};
      `SFL_OP_WRDI: a = '{K_WRDI, 2'h0, 2'h0, 1'b0, 1'b0};
      `SFL_OP_PROG_SEC: a = '{K_PROG_SEC, `SFL_ADDR_BYTES, 2'h0, 1'b1, 1'b0};
      `SFL_OP_READ_SEC: a = '{K_READ_SEC, `SFL_ADDR_BYTES, `SFL_SEC_DUMMY, 1'b0, 1'b1};
      `SFL_OP_READ_STATUS: a = '{K_READ_STATUS, 2'h0, 2'h0, 1'b0, 1'b1};
      `SFL_OP_WRITE_STATUS: a = '{K_WRITE_STATUS, 2'h0, 2'h0, 1'b1, 1'b0};
      `SFL_OP_READ_ID: a = '{K_READ_ID, 2'h0, 2'h0, 1'b0, 1'b1};
      `SFL_OP_SLEEP: a = '{K_SLEEP, 2'h0, 2'h0, 1'b0, 1'b0};
      `SFL_OP_WAKE: a = '{K_WAKE, 2'h0, 2'h0, 1'b0, 1'b0};
      default: a = '{K_NONE, 2'h0, 2'h0, 1'b0, 1'b0};
    endcase
    return a;
  endfunction : sfl_decode

endpackage : sfl_pkg

// ==== rtl/sfl_if.sv ====
interface sfl_if;

  // ===================================================================
  // Link wires
  logic cs_n;
  logic sck;
  logic mosi;
  logic so;
  logic so_oe;
  logic miso;

  // Released line idles high
  assign miso = so_oe ? so : 1'b1;

  modport dev (
    input cs_n,
    input sck,
    input mosi,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output mosi,
    input miso
  );

endinterface : sfl_if

// ==== rtl/sfl_sync.sv ====
module sfl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);

  // ===================================================================
  // Two-stage synchroniser
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : sfl_sync

// ==== rtl/sfl_host.sv ====
`include "sfl_defs.svh"

module sfl_host #(
  parameter int SCK_HALF = 4
) (
  sfl_if.host lnk,
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [8:0] cmd_wr_len,
  input wire logic [8:0] cmd_rd_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy
);
  import sfl_pkg::*;

  // ===================================================================
  // Clock divider sizing
  localparam int HALF_A = (SCK_HALF > `SFL_SCK_HALF_MIN) ? SCK_HALF : `SFL_SCK_HALF_MIN;
  localparam int HALF = (HALF_A > `SFL_SCK_HALF_SYNC) ? HALF_A : `SFL_SCK_HALF_SYNC;
  localparam int PW = $clog2(2 * HALF);
  localparam logic [PW-1:0] PH_RISE = PW'(HALF);
  localparam logic [PW-1:0] PH_END = PW'(2 * HALF - 1);

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_SETUP = 4'h2,
    H_BITS = 4'h4,
    H_HOLD = 4'h8
  } sfl_host_state_type;

  sfl_host_state_type st_ff, nxt_st;
  logic [PW-1:0] ph_ff, nxt_ph;
  logic [2:0] bit_ff, nxt_bit;
  logic [10:0] byte_ff, nxt_byte;
  logic [10:0] total_ff, nxt_total;
  logic [10:0] wr_start_ff, nxt_wr_start;
  logic [10:0] rd_start_ff, nxt_rd_start;
  logic [7:0] opc_ff, nxt_opc;
  logic [23:0] addr_ff, nxt_addr;
  logic [7:0] tx_ff, nxt_tx;
  logic [6:0] rx_ff, nxt_rx;
  logic cs_n_ff, nxt_cs_n;
  logic sck_ff, nxt_sck;
  logic mosi_ff, nxt_mosi;
  logic take_ff, nxt_take;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic miso_s;
  logic [7:0] tx_new;
  sfl_attr_type attr;

  sfl_sync #(.RST_VAL(1'b1)) u_sync_miso (
    .clk(clk_sys),
    .nrst(nrst),
    .d(lnk.miso),
    .q(miso_s)
  );

  assign attr = sfl_decode(cmd_opcode);

  // Byte sent at each frame position
  always_comb begin
    if (byte_ff == 11'h000) begin
      tx_new = opc_ff;
    end else if (byte_ff == 11'h001 && wr_start_ff > 11'h001) begin
      tx_new = addr_ff[23:16];
    end else if (byte_ff == 11'h002 && wr_start_ff > 11'h002) begin
      tx_new = addr_ff[15:8];
    end else if (byte_ff == 11'h003 && wr_start_ff > 11'h003) begin
      tx_new = addr_ff[7:0];
    end else if (byte_ff >= wr_start_ff && byte_ff < rd_start_ff) begin
      tx_new = wr_data;
    end else begin
      tx_new = 8'h00;
    end
  end

  // ===================================================================
  // Frame sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_byte = byte_ff;
    nxt_total = total_ff;
    nxt_wr_start = wr_start_ff;
    nxt_rd_start = rd_start_ff;
    nxt_opc = opc_ff;
    nxt_addr = addr_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_cs_n = cs_n_ff;
    nxt_sck = sck_ff;
    nxt_mosi = mosi_ff;
    nxt_take = 1'b0;
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    case (st_ff)
      H_IDLE: begin
        if (cmd_start) begin
          nxt_opc = cmd_opcode;
          nxt_addr = cmd_addr;
          // Address bytes then dummy bytes follow the opcode
          nxt_wr_start = 11'h001 + 11'(attr.n_addr) + 11'(attr.n_dummy);
          nxt_rd_start = nxt_wr_start + 11'(cmd_wr_len);
          nxt_total = nxt_rd_start + 11'(cmd_rd_len);
          nxt_byte = 11'h000;
          nxt_bit = 3'h0;
          nxt_ph = '0;
          nxt_cs_n = 1'b0;
          nxt_st = H_SETUP;
        end
      end
      H_SETUP: begin
        nxt_ph = ph_ff + PW'(1);
        if (ph_ff == PH_RISE - PW'(1)) begin
          nxt_ph = '0;
          nxt_st = H_BITS;
        end
      end
      H_BITS: begin
        nxt_ph = ph_ff + PW'(1);
        if (ph_ff == '0) begin
          if (bit_ff == 3'h0) begin
            nxt_tx = tx_new;
            nxt_mosi = tx_new[7];
            nxt_take = (byte_ff >= wr_start_ff) && (byte_ff < rd_start_ff);
          end else begin
            nxt_mosi = tx_ff[~bit_ff];
          end
        end
        if (ph_ff == PH_RISE) begin
          nxt_sck = 1'b1;
          nxt_rx = {rx_ff[5:0], miso_s};
          if (bit_ff == 3'h7 && byte_ff >= rd_start_ff) begin
            nxt_rd_data = {rx_ff, miso_s};
            nxt_rd_valid = 1'b1;
          end
        end
        if (ph_ff == PH_END) begin
          nxt_sck = 1'b0;
          nxt_ph = '0;
          nxt_bit = bit_ff + 3'h1;
          if (bit_ff == 3'h7) begin
            nxt_byte = byte_ff + 11'h001;
            if (byte_ff == total_ff - 11'h001) begin
              nxt_st = H_HOLD;
            end
          end
        end
      end
      H_HOLD: begin
        nxt_ph = ph_ff + PW'(1);
        if (ph_ff == PH_RISE - PW'(1)) begin
          nxt_cs_n = 1'b1;
          nxt_st = H_IDLE;
        end
      end
      default: begin
        nxt_st = H_IDLE;
        nxt_cs_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= H_IDLE;
      ph_ff <= '0;
      bit_ff <= 3'h0;
      byte_ff <= 11'h000;
      total_ff <= 11'h000;
      wr_start_ff <= 11'h000;
      rd_start_ff <= 11'h000;
      opc_ff <= 8'h00;
      addr_ff <= 24'h000000;
      tx_ff <= 8'h00;
      rx_ff <= 7'h00;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
      take_ff <= 1'b0;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      byte_ff <= nxt_byte;
      total_ff <= nxt_total;
      wr_start_ff <= nxt_wr_start;
      rd_start_ff <= nxt_rd_start;
      opc_ff <= nxt_opc;
      addr_ff <= nxt_addr;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      cs_n_ff <= nxt_cs_n;
      sck_ff <= nxt_sck;
      mosi_ff <= nxt_mosi;
      take_ff <= nxt_take;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign lnk.cs_n = cs_n_ff;
  assign lnk.sck = sck_ff;
  assign lnk.mosi = mosi_ff;
  assign wr_take = take_ff;
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign busy = ~cs_n_ff;

endmodule : sfl_host

// ==== test/sfl_link_properties.sv ====
module sfl_link_properties (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic so,
  input wire logic so_oe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Bit count and opcode
  logic sck_ff;
  logic nxt_sck;
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic [7:0] op_ff;
  logic [7:0] nxt_op;
  always_comb begin
    nxt_sck = sck;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    if (cs_n) begin
      nxt_cnt = 7'h0;
      nxt_op = 8'h0;
    end else if (sck && !sck_ff && cnt_ff != 7'h7f) begin
      nxt_cnt = cnt_ff + 7'h1;
      if (cnt_ff < 7'h8) begin
        nxt_op = {op_ff[6:0], mosi};
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_ff <= 1'b0;
      cnt_ff <= 7'h0;
      op_ff <= 8'h0;
    end else begin
      sck_ff <= nxt_sck;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  a_oe_off_desel: assert property (cs_n |-> !so_oe) else $error("so_oe while deselected");
  a_sck_idle_low: assert property (cs_n |-> !sck) else $error("sck not idle low");
  a_so_hold_high: assert property (so_oe && $past(so_oe) && sck && $past(sck) |-> $stable(so))
    else $error("so moved while sck high");
  a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  a_oe_on_fall: assert property ($rose(so_oe) |-> !sck) else $error("so_oe rose off fall");
  a_oe_after_op: assert property ($rose(so_oe) |-> cnt_ff >= 7'h8)
    else $error("output before opcode");
  a_fast_dummy: assert property ($rose(so_oe) && op_ff == 8'h0b |-> cnt_ff == 7'h28)
    else $error("fast read start bit wrong");
  a_slow_nodummy: assert property ($rose(so_oe) && op_ff == 8'h03 |-> cnt_ff == 7'h20)
    else $error("slow read start bit wrong");
  a_bad_op_quiet: assert property (cnt_ff >= 7'h8 && op_ff == 8'hff |-> miso && !so_oe)
    else $error("output after unknown opcode");
endmodule : sfl_link_properties

// ==== test/serial_flash_command_front_end_tb.sv ====
`include "sfl_defs.svh"

module serial_flash_command_front_end_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfl_pkg::*;
  logic clk_sys;
  logic nrst;
  logic cmd_start;
  logic [7:0] cmd_opcode;
  logic [23:0] cmd_addr;
  logic [8:0] cmd_wr_len;
  logic [8:0] cmd_rd_len;
  logic [7:0] wr_data;
  logic wr_take;
  logic [7:0] rd_data;
  logic rd_valid;
  logic busy;
  logic [7:0] dev_rd;
  logic [`SFL_ADDR_W-1:0] rd_addr;
  sfl_kind_type rd_kind;
  logic cmd_valid;
  sfl_kind_type cmd_kind;
  logic [7:0] d_opcode;
  logic [`SFL_ADDR_W-1:0] d_addr;
  logic [8:0] cmd_len;
  logic [7:0] wdata;
  logic wdata_valid;
  int error_cnt;
  int n_checks;
  int seed;
  logic [47:0] rq[$];
  logic [47:0] cq[$];
  logic [47:0] wq[$];
  logic [7:0] ops [17] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h06, 8'h04, 8'h36, 8'h39,
    8'hb9, 8'hab, 8'h01, 8'h9b, 8'h9f, 8'h05, 8'h77, 8'h3c};
  sfl_kind_type kinds [17] = '{K_ERASE, K_ERASE, K_ERASE, K_CHIP_ERASE, K_CHIP_ERASE, K_WREN,
    K_WRDI, K_PROTECT, K_UNPROTECT, K_SLEEP, K_WAKE, K_WRITE_STATUS, K_PROG_SEC, K_READ_ID,
    K_READ_STATUS, K_READ_SEC, K_READ_PROT};
  logic [8:0] wls [17] = '{11: 9'h001, 12: 9'h002, default: 9'h000};
  logic [8:0] rls [17] = '{13: 9'h005, 14: 9'h002, 15: 9'h001, 16: 9'h001, default: 9'h000};
  sfl_if lnk();
  sfl_host #(.SCK_HALF(4)) u_sfl_host (.lnk(lnk), .clk_sys(clk_sys), .nrst(nrst),
    .cmd_start(cmd_start), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
    .cmd_wr_len(cmd_wr_len), .cmd_rd_len(cmd_rd_len), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
  sfl_dev u_sfl_dev (.lnk(lnk), .clk_sys(clk_sys), .nrst(nrst), .rd_data(dev_rd),
    .rd_addr(rd_addr), .rd_kind(rd_kind), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_opcode(d_opcode), .cmd_addr(d_addr), .cmd_len(cmd_len), .wdata(wdata),
    .wdata_valid(wdata_valid));
  sfl_link_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .cs_n(lnk.cs_n),
    .sck(lnk.sck), .mosi(lnk.mosi), .so(lnk.so), .so_oe(lnk.so_oe), .miso(lnk.miso));
  // Array returns address pattern, other sources a constant
  assign dev_rd = (rd_kind === K_READ) ? (rd_addr[7:0] ^ 8'h5a) : 8'hc3;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic await_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl) begin
      @(posedge clk_sys);
      n++;
      if (n > 2000) begin
        error_cnt++;
        conclude();
      end
    end
  endtask : await_busy
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [8:0] wl,
    input logic [8:0] rl);
    cmd_opcode <= op;
    cmd_addr <= a;
    cmd_wr_len <= wl;
    cmd_rd_len <= rl;
    cmd_start <= 1'b1;
    @(posedge clk_sys);
    cmd_start <= 1'b0;
    @(posedge clk_sys);
    await_busy(1'b1);
    await_busy(1'b0);
    repeat (12) @(posedge clk_sys);
  endtask : run
  task automatic rd_array(input logic [7:0] op, input logic [23:0] a, input logic [8:0] n);
    logic [17:0] p;
    p = a[17:0];
    cq.push_back({8'h0, K_READ, op, p, 9'h0});
    for (int i = 0; i < n; i++) begin
      rq.push_back({40'h0, p[7:0] ^ 8'h5a});
      p = p + 18'h1;
    end
    run(op, a, 9'h0, n);
  endtask : rd_array
  // ==========
  // Write data driver
  always @(posedge clk_sys) begin
    if (wr_take === 1'b1) begin
      wq.push_back({40'h0, wr_data});
      wr_data <= 8'($random(seed));
    end
  end
  // ==========
  // Output monitor
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) check({40'h0, rd_data}, rq.size() ? rq.pop_front() : 48'hx);
    if (cmd_valid === 1'b1) check({8'h0, cmd_kind, d_opcode, d_addr, cmd_len},
      cq.size() ? cq.pop_front() : 48'hx);
    if (wdata_valid === 1'b1) check({40'h0, wdata}, wq.size() ? wq.pop_front() : 48'hx);
  end
  initial begin
    seed = 32'hcf2f751d;
    error_cnt = 0;
    n_checks = 0;
    nrst = 1'b0;
    cmd_start = 1'b0;
    cmd_opcode = 8'h0;
    cmd_addr = 24'h0;
    cmd_wr_len = 9'h0;
    cmd_rd_len = 9'h0;
    wr_data = 8'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 17; i++) begin
      cq.push_back({8'h0, kinds[i], ops[i], 18'h0, wls[i]});
      for (int j = 0; j < rls[i]; j++) rq.push_back({40'h0, (j < 4 || i != 13) ? 8'hc3 : 8'hff});
      run(ops[i], 24'h0, wls[i], rls[i]);
    end
    rd_array(8'h0b, 24'hfffffe, 9'h4);
    rd_array(8'h03, 24'($random(seed)), 9'h2);
    cmd_addr <= 24'($random(seed));
    @(posedge clk_sys);
    cq.push_back({8'h0, K_PROGRAM, 8'h02, cmd_addr[17:0], 9'h3});
    run(8'h02, cmd_addr, 9'h3, 9'h0);
    rq.push_back({40'h0, 8'hff});
    run(8'hff, 24'h0, 9'h0, 9'h1);
    check(48'(rq.size() + cq.size() + wq.size()), 48'h0);
    conclude();
  end
endmodule : serial_flash_command_front_end_tb
